// >>> hdl/mcu_bus_consts.svh
`ifndef MCU_BUS_CONSTS_SVH
`define MCU_BUS_CONSTS_SVH

// ----------------------------------------------------------------
// Mode selection values
// ----------------------------------------------------------------
`define MCU_MODE_VALUE       8'h08
`define MODE_RESET_VALUE     8'h00

// ----------------------------------------------------------------
// Longest strobe widths and CS-to-read delay in bus clocks, taken while wait is low
// ----------------------------------------------------------------
`define ALE_MAX_CLK          3'h2
`define CS_MAX_CLK           3'h3
`define WR_MAX_CLK           3'h6
`define RD_MAX_CLK           3'h5

// ----------------------------------------------------------------
// Bus clock, field positions
// ----------------------------------------------------------------
`define BUS_HALF_DIV_DEFAULT 4
`define GP_FIRST_BIT         0
`define GP_WAIT_BIT          1
`define SYNC_WIDTH           11

`endif

// >>> hdl/mcu_bus_pkg.sv
package mcu_bus_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_READ_EXT,
    OP_WRITE,
    OP_WRITE_EXT,
    OP_SET_GP,
    OP_READ_GP,
    OP_WAIT_HIGH,
    OP_WAIT_LOW
  } cmd_op_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ALE,
    S_CSDLY,
    S_DSETUP,
    S_STROBE,
    S_WR_END,
    S_HOLD,
    S_WAITLVL
  } bus_state_t;

endpackage : mcu_bus_pkg

// >>> hdl/pin_sample_if.sv
interface pin_sample_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport sampler (input raw, output clean);
  modport user    (output raw, input clean);
endinterface : pin_sample_if

// >>> hdl/pin_sampler.sv
module pin_sampler #(
  parameter int W = 1
) (
  input  wire logic     mclk,
  input  wire logic     srst,
  input  wire logic     clk_en,
  pin_sample_if.sampler pins
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] clean_reg;
  logic [W-1:0] clean_next;

  // ----------------------------------------------------------------
  // A bit changes only once the second and third stages agree
  // ----------------------------------------------------------------
  always_comb
  begin
    clean_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (clean_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s1_reg    <= '1;
      s2_reg    <= '1;
      s3_reg    <= '1;
      clean_reg <= '1;
    end
    else if (clk_en)
    begin
      s1_reg    <= pins.raw;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      clean_reg <= clean_next;
    end
  end

  assign pins.clean = clean_reg;

endmodule : pin_sampler

// >>> hdl/mcu_host_bus_emulator.sv
`include "mcu_bus_consts.svh"

module mcu_host_bus_emulator #(
  parameter int BUS_HALF_DIV = `BUS_HALF_DIV_DEFAULT
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire logic                 mode_set_valid,
  input  wire logic [7:0]           mode_set_value,
  output logic                      mode_active,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire mcu_bus_pkg::cmd_op_t cmd_op,
  input  wire logic [15:0]          cmd_addr,
  input  wire logic [7:0]           cmd_data,
  output logic                      resp_valid,
  output logic [7:0]                resp_data,
  input  wire logic [7:0]           muxbus_in,
  output logic [7:0]                muxbus_out,
  output logic [7:0]                muxbus_oe,
  output logic [7:0]                ext_addr,
  output logic                      ale,
  output logic                      cs_n,
  output logic                      rd_n,
  output logic                      wr_n,
  input  wire logic                 bus_wait_in,
  input  wire logic                 aux_gp_line_first_in,
  output logic                      aux_gp_line_first_out,
  output logic                      aux_gp_line_first_oe,
  input  wire logic                 aux_gp_line_wait_in,
  output logic                      aux_gp_line_wait_out,
  output logic                      aux_gp_line_wait_oe,
  output logic                      bus_clk_mon
);

  // Read data passes the pin sampler, which needs five mclk inside one bus clock
  if (BUS_HALF_DIV < 3 || BUS_HALF_DIV > 65535)
  begin : g_div_check
    $error("BUS_HALF_DIV out of range");
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  pin_sample_if #(.W(`SYNC_WIDTH)) sync_pins ();

  assign sync_pins.raw = {aux_gp_line_wait_in, aux_gp_line_first_in, bus_wait_in, muxbus_in};

  pin_sampler #(.W(`SYNC_WIDTH)) u_sampler (
    .mclk   (mclk),
    .srst   (srst),
    .clk_en (clk_en),
    .pins   (sync_pins.sampler)
  );

  logic [7:0] bus_data_s;
  logic       wait_low_s;
  logic [1:0] gp_in_s;

  assign bus_data_s = sync_pins.clean[7:0];
  assign wait_low_s = ~sync_pins.clean[8];
  assign gp_in_s    = sync_pins.clean[10:9];

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  logic [15:0] half_cnt_reg;
  logic [15:0] half_cnt_next;
  logic        clk_mon_reg;
  logic        clk_mon_next;
  logic        half_end;
  logic        tick_rise;
  logic        tick_fall;

  assign half_end  = (half_cnt_reg == 16'(BUS_HALF_DIV - 1));
  assign tick_rise = half_end & ~clk_mon_reg;
  assign tick_fall = half_end & clk_mon_reg;

  always_comb
  begin
    half_cnt_next = half_end ? 16'h0000 : half_cnt_reg + 16'h0001;
    clk_mon_next  = half_end ? ~clk_mon_reg : clk_mon_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      half_cnt_reg <= 16'h0000;
      clk_mon_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      half_cnt_reg <= half_cnt_next;
      clk_mon_reg  <= clk_mon_next;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  function automatic logic stretch(input logic wait_low, input logic [2:0] cnt, input logic [2:0] max_clk);
    stretch = wait_low && (cnt < max_clk - 3'h1);
  endfunction : stretch

  mcu_bus_pkg::bus_state_t state_reg, state_next;
  mcu_bus_pkg::cmd_op_t    op_reg, op_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [7:0]  data_reg, data_next;
  logic        active_reg, active_next;
  logic        ready_reg, ready_next;
  logic        resp_valid_reg, resp_valid_next;
  logic [7:0]  resp_data_reg, resp_data_next;
  logic [7:0]  ad_out_reg, ad_out_next;
  logic [7:0]  ad_oe_reg, ad_oe_next;
  logic [7:0]  ext_addr_reg, ext_addr_next;
  logic        ale_reg, ale_next;
  logic        cs_n_reg, cs_n_next;
  logic        rd_n_reg, rd_n_next;
  logic        wr_n_reg, wr_n_next;
  logic [1:0]  gp_val_reg, gp_val_next;
  logic [1:0]  gp_dir_reg, gp_dir_next;
  logic        is_write;

  assign is_write = (op_reg == mcu_bus_pkg::OP_WRITE) || (op_reg == mcu_bus_pkg::OP_WRITE_EXT);

  always_comb
  begin
    state_next      = state_reg;
    op_next         = op_reg;
    cnt_next        = cnt_reg;
    data_next       = data_reg;
    active_next     = active_reg;
    resp_valid_next = 1'b0;
    resp_data_next  = resp_data_reg;
    ad_out_next     = ad_out_reg;
    ad_oe_next      = ad_oe_reg;
    ext_addr_next   = ext_addr_reg;
    ale_next        = ale_reg;
    cs_n_next       = cs_n_reg;
    rd_n_next       = rd_n_reg;
    wr_n_next       = wr_n_reg;
    gp_val_next     = gp_val_reg;
    gp_dir_next     = gp_dir_reg;

    unique case (state_reg)
      mcu_bus_pkg::S_IDLE:
      begin
        if (cmd_valid && ready_reg)
        begin
          op_next   = cmd_op;
          data_next = cmd_data;
          unique case (cmd_op)
            mcu_bus_pkg::OP_READ, mcu_bus_pkg::OP_WRITE,
            mcu_bus_pkg::OP_READ_EXT, mcu_bus_pkg::OP_WRITE_EXT:
            begin
              if (cmd_op == mcu_bus_pkg::OP_READ_EXT || cmd_op == mcu_bus_pkg::OP_WRITE_EXT)
                ext_addr_next = cmd_addr[15:8];
              ad_out_next = cmd_addr[7:0];
              ad_oe_next  = 8'hff;
              state_next  = mcu_bus_pkg::S_ADDR;
            end
            mcu_bus_pkg::OP_SET_GP:
            begin
              gp_val_next = cmd_data[1:0];
              gp_dir_next = cmd_addr[1:0];
            end
            mcu_bus_pkg::OP_READ_GP:
            begin
              resp_valid_next = 1'b1;
              resp_data_next  = {6'h00, gp_in_s};
            end
            mcu_bus_pkg::OP_WAIT_HIGH, mcu_bus_pkg::OP_WAIT_LOW:
              state_next = mcu_bus_pkg::S_WAITLVL;
          endcase
        end
      end
      // Level is judged on the sampled pin; its direction stays as the last OP_SET_GP left it
      mcu_bus_pkg::S_WAITLVL:
      begin
        if (gp_in_s[`GP_WAIT_BIT] == (op_reg == mcu_bus_pkg::OP_WAIT_HIGH))
          state_next = mcu_bus_pkg::S_IDLE;
      end
      mcu_bus_pkg::S_ADDR:
      begin
        if (tick_rise)
        begin
          ale_next   = 1'b1;
          cnt_next   = 3'h0;
          state_next = mcu_bus_pkg::S_ALE;
        end
      end
      mcu_bus_pkg::S_ALE:
      begin
        if (tick_rise)
        begin
          if (stretch(wait_low_s, cnt_reg, `ALE_MAX_CLK))
            cnt_next = cnt_reg + 3'h1;
          else
          begin
            ale_next  = 1'b0;
            cs_n_next = 1'b0;
            cnt_next  = 3'h0;
            if (is_write)
            begin
              ad_out_next = data_reg;
              state_next  = mcu_bus_pkg::S_DSETUP;
            end
            else
              state_next = mcu_bus_pkg::S_CSDLY;
          end
        end
      end
      mcu_bus_pkg::S_CSDLY:
      begin
        if (tick_rise)
        begin
          if (stretch(wait_low_s, cnt_reg, `CS_MAX_CLK))
            cnt_next = cnt_reg + 3'h1;
          else
          begin
            ad_oe_next = 8'h00;
            rd_n_next  = 1'b0;
            cnt_next   = 3'h0;
            state_next = mcu_bus_pkg::S_STROBE;
          end
        end
      end
      mcu_bus_pkg::S_DSETUP:
      begin
        if (tick_rise)
        begin
          wr_n_next  = 1'b0;
          cnt_next   = 3'h0;
          state_next = mcu_bus_pkg::S_STROBE;
        end
      end
      mcu_bus_pkg::S_STROBE:
      begin
        if (tick_rise)
        begin
          if (stretch(wait_low_s, cnt_reg, is_write ? `WR_MAX_CLK : `RD_MAX_CLK))
            cnt_next = cnt_reg + 3'h1;
          else if (is_write)
          begin
            wr_n_next  = 1'b1;
            state_next = mcu_bus_pkg::S_WR_END;
          end
          else
          begin
            rd_n_next       = 1'b1;
            cs_n_next       = 1'b1;
            resp_valid_next = 1'b1;
            resp_data_next  = bus_data_s;
            state_next      = mcu_bus_pkg::S_IDLE;
          end
        end
      end
      mcu_bus_pkg::S_WR_END:
      begin
        if (tick_fall)
        begin
          cs_n_next  = 1'b1;
          state_next = mcu_bus_pkg::S_HOLD;
        end
      end
      mcu_bus_pkg::S_HOLD:
      begin
        // Data stays driven past the select edge
        if (tick_rise)
        begin
          ad_oe_next = 8'h00;
          state_next = mcu_bus_pkg::S_IDLE;
        end
      end
    endcase

    if (mode_set_valid)
    begin
      active_next = (mode_set_value == `MCU_MODE_VALUE);
      if (mode_set_value == `MODE_RESET_VALUE)
      begin
        state_next      = mcu_bus_pkg::S_IDLE;
        resp_valid_next = 1'b0;
        ad_oe_next      = 8'h00;
        ext_addr_next   = 8'h00;
        ale_next        = 1'b0;
        cs_n_next       = 1'b1;
        rd_n_next       = 1'b1;
        wr_n_next       = 1'b1;
        gp_val_next     = 2'h0;
        gp_dir_next     = 2'h0;
      end
    end
    // Accept a new command only when the bus will be idle next cycle
    ready_next = active_next && (state_next == mcu_bus_pkg::S_IDLE) && !(cmd_valid && ready_reg);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg      <= mcu_bus_pkg::S_IDLE;
      op_reg         <= mcu_bus_pkg::OP_READ;
      cnt_reg        <= 3'h0;
      data_reg       <= 8'h00;
      active_reg     <= 1'b0;
      ready_reg      <= 1'b0;
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= 8'h00;
      ad_out_reg     <= 8'h00;
      ad_oe_reg      <= 8'h00;
      ext_addr_reg   <= 8'h00;
      ale_reg        <= 1'b0;
      cs_n_reg       <= 1'b1;
      rd_n_reg       <= 1'b1;
      wr_n_reg       <= 1'b1;
      gp_val_reg     <= 2'h0;
      gp_dir_reg     <= 2'h0;
    end
    else if (clk_en)
    begin
      state_reg      <= state_next;
      op_reg         <= op_next;
      cnt_reg        <= cnt_next;
      data_reg       <= data_next;
      active_reg     <= active_next;
      ready_reg      <= ready_next;
      resp_valid_reg <= resp_valid_next;
      resp_data_reg  <= resp_data_next;
      ad_out_reg     <= ad_out_next;
      ad_oe_reg      <= ad_oe_next;
      ext_addr_reg   <= ext_addr_next;
      ale_reg        <= ale_next;
      cs_n_reg       <= cs_n_next;
      rd_n_reg       <= rd_n_next;
      wr_n_reg       <= wr_n_next;
      gp_val_reg     <= gp_val_next;
      gp_dir_reg     <= gp_dir_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mode_active           = active_reg;
  assign cmd_ready             = ready_reg;
  assign resp_valid            = resp_valid_reg;
  assign resp_data             = resp_data_reg;
  assign muxbus_out            = ad_out_reg;
  assign muxbus_oe             = ad_oe_reg;
  assign ext_addr              = ext_addr_reg;
  assign ale                   = ale_reg;
  assign cs_n                  = cs_n_reg;
  assign rd_n                  = rd_n_reg;
  assign wr_n                  = wr_n_reg;
  assign aux_gp_line_first_out = gp_val_reg[`GP_FIRST_BIT];
  assign aux_gp_line_first_oe  = gp_dir_reg[`GP_FIRST_BIT];
  assign aux_gp_line_wait_out  = gp_val_reg[`GP_WAIT_BIT];
  assign aux_gp_line_wait_oe   = gp_dir_reg[`GP_WAIT_BIT];
  assign bus_clk_mon           = clk_mon_reg;

endmodule : mcu_host_bus_emulator

// >>> dv/mcu_bus_props.sv
// ----------------------------------------------------------------
// Bus cycle checker
// ----------------------------------------------------------------
module mcu_bus_props #(
  parameter int BUS_HALF_DIV = 4
) (
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire logic                 clk_en,
  input wire logic                 mode_set_valid,
  input wire logic [7:0]           mode_set_value,
  input wire logic                 mode_active,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_ready,
  input wire mcu_bus_pkg::cmd_op_t cmd_op,
  input wire logic [15:0]          cmd_addr,
  input wire logic                 resp_valid,
  input wire logic [7:0]           muxbus_oe,
  input wire logic [7:0]           ext_addr,
  input wire logic                 ale,
  input wire logic                 cs_n,
  input wire logic                 rd_n,
  input wire logic                 wr_n,
  input wire logic                 bus_clk_mon
);
  localparam int BCLK   = 2 * BUS_HALF_DIV;
  localparam int CS_LAG = BUS_HALF_DIV + 1;
  logic [7:0] wr_cnt_reg, wr_cnt_next, rd_cnt_reg, rd_cnt_next, mon_cnt_reg, mon_cnt_next;
  logic       mon_prev_reg;
  logic       take;
  logic [7:0] addr_hi;
  assign take    = cmd_valid && cmd_ready && clk_en;
  assign addr_hi = cmd_addr[15:8];
  always_comb
  begin
    wr_cnt_next  = wr_n ? 8'h00 : wr_cnt_reg + {7'h00, clk_en};
    rd_cnt_next  = rd_n ? 8'h00 : rd_cnt_reg + {7'h00, clk_en};
    mon_cnt_next = (bus_clk_mon != mon_prev_reg) ? 8'h01 : mon_cnt_reg + {7'h00, clk_en};
  end
  // Counters hold a strobe's low time in clk_en-enabled mclk cycles on the cycle it ends
  always_ff @(posedge mclk)
  begin
    wr_cnt_reg   <= srst ? 8'h00 : wr_cnt_next;
    rd_cnt_reg   <= srst ? 8'h00 : rd_cnt_next;
    mon_cnt_reg  <= srst ? 8'h01 : mon_cnt_next;
    mon_prev_reg <= srst ? 1'b0 : bus_clk_mon;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_wr_end; $rose(wr_n) ##0 (!cs_n && muxbus_oe == 8'hff); endsequence
  sequence s_cs_release; ##[1:CS_LAG] (cs_n && muxbus_oe == 8'hff); endsequence
  property p_reset_out; $fell(srst) |-> cs_n && rd_n && wr_n && !ale && muxbus_oe == 8'h00 && !cmd_ready; endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
  property p_mode_on; mode_set_valid && clk_en && mode_set_value == 8'h08 |=> mode_active; endproperty
  a_mode_on: assert property (p_mode_on) else $error("mode not entered");
  property p_mode_off; mode_set_valid && clk_en && mode_set_value != 8'h08 |=> !mode_active && !cmd_ready; endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode not left");
  property p_rd_float; !rd_n |-> muxbus_oe == 8'h00 && !cs_n && wr_n; endproperty
  a_rd_float: assert property (p_rd_float) else $error("lines driven during read");
  property p_wr_drive; !wr_n |-> muxbus_oe == 8'hff && !cs_n && rd_n; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("data not driven during write");
  property p_ale_addr; ale |-> muxbus_oe == 8'hff && cs_n; endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("address not driven with latch");
  property p_wr_len; $rose(wr_n) |-> wr_cnt_reg >= BCLK && wr_cnt_reg <= 6 * BCLK; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width");
  property p_rd_len; $rose(rd_n) |-> rd_cnt_reg >= BCLK && rd_cnt_reg <= 5 * BCLK; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe width");
  property p_cs_after_wr; s_wr_end |-> s_cs_release; endproperty
  a_cs_after_wr: assert property (p_cs_after_wr) else $error("select release after write");
  property p_ext_plain; take && (cmd_op == mcu_bus_pkg::OP_READ || cmd_op == mcu_bus_pkg::OP_WRITE) |=> $stable(ext_addr);
  endproperty
  a_ext_plain: assert property (p_ext_plain) else $error("plain cycle moved upper address");
  property p_ext_load; take && (cmd_op == mcu_bus_pkg::OP_READ_EXT || cmd_op == mcu_bus_pkg::OP_WRITE_EXT) |=>
    ext_addr == $past(addr_hi); endproperty
  a_ext_load: assert property (p_ext_load) else $error("upper address not loaded");
  property p_gp_resp; take && cmd_op == mcu_bus_pkg::OP_READ_GP |=> resp_valid; endproperty
  a_gp_resp: assert property (p_gp_resp) else $error("line read gave no answer");
  property p_clk_mon; mon_cnt_reg <= BUS_HALF_DIV + 1; endproperty
  a_clk_mon: assert property (p_clk_mon) else $error("bus clock monitor stalled");
endmodule : mcu_bus_props

bind mcu_host_bus_emulator mcu_bus_props #(.BUS_HALF_DIV(BUS_HALF_DIV)) mcu_bus_props_i (.mclk, .srst, .clk_en,
  .mode_set_valid, .mode_set_value, .mode_active, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .resp_valid,
  .muxbus_oe, .ext_addr, .ale, .cs_n, .rd_n, .wr_n, .bus_clk_mon);

// >>> dv/mcu_periph_model.sv
module mcu_periph_model (
  input  wire logic       mclk,
  input  wire logic       ale,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] muxbus_out,
  input  wire logic [7:0] muxbus_oe,
  input  wire logic       aux_gp_line_first_out,
  input  wire logic       aux_gp_line_first_oe,
  input  wire logic       aux_gp_line_wait_out,
  input  wire logic       aux_gp_line_wait_oe,
  input  wire logic       stretch,
  input  wire logic       irq,
  output logic [7:0]      muxbus_in,
  output logic            bus_wait_in,
  output logic            aux_gp_line_first_in,
  output logic            aux_gp_line_wait_in,
  output logic [7:0]      wr_len = 8'h00,
  output logic [7:0]      rd_len = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  logic [7:0] addr_reg;
  logic [7:0] wr_cnt  = 8'h00;
  logic [7:0] rd_cnt  = 8'h00;
  logic       wr_prev = 1'b1;
  logic [7:0] pins;
  // Released lines other than the wait line, which follows irq, and the data lines during a read, which carry mem, sit at the pull-up level, never at the last value
  assign pins                 = (!rd_n && !cs_n) ? mem[addr_reg[3:0]] : 8'hff;
  assign muxbus_in            = (muxbus_out & muxbus_oe) | (pins & ~muxbus_oe);
  assign bus_wait_in          = !stretch;
  assign aux_gp_line_first_in = aux_gp_line_first_oe ? aux_gp_line_first_out : 1'b1;
  assign aux_gp_line_wait_in  = aux_gp_line_wait_oe ? aux_gp_line_wait_out : irq;
  always_ff @(posedge mclk)
  begin
    wr_prev <= wr_n;
    if (ale)
      addr_reg <= muxbus_in;
    if (wr_n && !wr_prev)
      mem[addr_reg[3:0]] <= muxbus_in;
    wr_cnt <= wr_n ? 8'h00 : wr_cnt + 8'h01;
    rd_cnt <= rd_n ? 8'h00 : rd_cnt + 8'h01;
    if (wr_n && wr_cnt != 8'h00)
      wr_len <= wr_cnt;
    if (rd_n && rd_cnt != 8'h00)
      rd_len <= rd_cnt;
  end
endmodule : mcu_periph_model

// >>> dv/mcu_host_bus_emulator_test.sv
module mcu_host_bus_emulator_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HD = 4;
  logic                 mclk = 1'b0, srst = 1'b1, clk_en = 1'b1, mode_set_valid = 1'b0, cmd_valid = 1'b0;
  logic [7:0]           mode_set_value = 8'h00, cmd_data = 8'h00;
  logic [15:0]          cmd_addr = 16'h0000;
  mcu_bus_pkg::cmd_op_t cmd_op = mcu_bus_pkg::OP_READ;
  logic                 stretch = 1'b0, irq = 1'b1;
  logic                 mode_active, cmd_ready, resp_valid, ale, cs_n, rd_n, wr_n, bus_wait_in, bus_clk_mon;
  logic [7:0]           resp_data, muxbus_in, muxbus_out, muxbus_oe, ext_addr, wr_len, rd_len;
  logic                 aux_gp_line_first_in, aux_gp_line_first_out, aux_gp_line_first_oe;
  logic                 aux_gp_line_wait_in, aux_gp_line_wait_out, aux_gp_line_wait_oe;
  int                   miscompares = 0, n_checks = 0;

  mcu_host_bus_emulator #(.BUS_HALF_DIV(HD)) mcu_host_bus_emulator_i (.mclk, .srst, .clk_en, .mode_set_valid,
    .mode_set_value, .mode_active, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .resp_valid, .resp_data,
    .muxbus_in, .muxbus_out, .muxbus_oe, .ext_addr, .ale, .cs_n, .rd_n, .wr_n, .bus_wait_in, .aux_gp_line_first_in,
    .aux_gp_line_first_out, .aux_gp_line_first_oe, .aux_gp_line_wait_in, .aux_gp_line_wait_out,
    .aux_gp_line_wait_oe, .bus_clk_mon);
  mcu_periph_model mcu_periph_model_i (.mclk, .ale, .cs_n, .rd_n, .wr_n, .muxbus_out, .muxbus_oe,
    .aux_gp_line_first_out, .aux_gp_line_first_oe, .aux_gp_line_wait_out, .aux_gp_line_wait_oe, .stretch, .irq,
    .muxbus_in, .bus_wait_in, .aux_gp_line_first_in, .aux_gp_line_wait_in, .wr_len, .rd_len);

  always #2 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic tmo;
    miscompares++;
    report_and_stop();
  endtask : tmo

  task automatic wait_ready;
    int i;
    for (i = 0; i < 4000 && cmd_ready !== 1'b1; i++) @(negedge mclk);
    if (i == 4000) tmo();
  endtask : wait_ready

  // Taken at the rising edge between the two falling edges
  task automatic send(input mcu_bus_pkg::cmd_op_t op, input logic [15:0] addr, input logic [7:0] data);
    @(negedge mclk);
    wait_ready();
    cmd_op    = op;
    cmd_addr  = addr;
    cmd_data  = data;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : send

  task automatic get_resp(output logic [7:0] d);
    int i;
    for (i = 0; i < 4000 && resp_valid !== 1'b1; i++) @(negedge mclk);
    if (i == 4000) tmo();
    d = resp_data;
    @(negedge mclk);
  endtask : get_resp

  task automatic set_mode(input logic [7:0] v, input logic exp);
    @(negedge mclk);
    mode_set_valid = 1'b1;
    mode_set_value = v;
    @(negedge mclk);
    mode_set_valid = 1'b0;
    chk(mode_active, exp);
    chk(cmd_ready, exp);
  endtask : set_mode

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset;
    chk({muxbus_oe, cs_n, rd_n, wr_n, ale, mode_active, cmd_ready, 2'b00}, 16'h00e0);
    chk(ext_addr, 8'h00);
  endtask : sc_reset

  task automatic sc_plain;
    logic [7:0] d;
    send(mcu_bus_pkg::OP_WRITE_EXT, 16'h3a05, 8'hc3);
    wait_ready();
    chk(ext_addr, 8'h3a);
    chk(mcu_periph_model_i.mem[5], 8'hc3);
    chk(wr_len, 16'(2 * HD));
    send(mcu_bus_pkg::OP_WRITE, 16'h7706, 8'h5e);
    wait_ready();
    chk(ext_addr, 8'h3a);
    chk(mcu_periph_model_i.mem[6], 8'h5e);
    send(mcu_bus_pkg::OP_READ_EXT, 16'h1205, 8'h00);
    get_resp(d);
    chk(d, 8'hc3);
    chk(rd_len, 16'(2 * HD));
    chk(ext_addr, 8'h12);
  endtask : sc_plain

  // Wait held low long enough to pass the input synchroniser
  task automatic sc_stretch;
    logic [7:0] d;
    stretch = 1'b1;
    repeat (8) @(negedge mclk);
    send(mcu_bus_pkg::OP_WRITE, 16'h0009, 8'ha7);
    wait_ready();
    chk(wr_len, 16'(12 * HD));
    chk(mcu_periph_model_i.mem[9], 8'ha7);
    send(mcu_bus_pkg::OP_READ, 16'h0009, 8'h00);
    get_resp(d);
    chk(d, 8'ha7);
    chk(rd_len, 16'(10 * HD));
    stretch = 1'b0;
  endtask : sc_stretch

  task automatic sc_gp;
    logic [7:0] d;
    send(mcu_bus_pkg::OP_SET_GP, 16'h0001, 8'h01);
    wait_ready();
    chk({aux_gp_line_first_oe, aux_gp_line_first_out, aux_gp_line_wait_oe, aux_gp_line_wait_out}, 16'h000c);
    repeat (8) @(negedge mclk);
    send(mcu_bus_pkg::OP_READ_GP, 16'h0000, 8'h00);
    get_resp(d);
    chk(d, 8'h03);
    send(mcu_bus_pkg::OP_SET_GP, 16'h0001, 8'h00);
    repeat (8) @(negedge mclk);
    send(mcu_bus_pkg::OP_READ_GP, 16'h0000, 8'h00);
    get_resp(d);
    chk(d, 8'h02);
  endtask : sc_gp

  task automatic sc_irq;
    logic [7:0] d;
    irq = 1'b0;
    repeat (8) @(negedge mclk);
    send(mcu_bus_pkg::OP_WAIT_HIGH, 16'h0000, 8'h00);
    repeat (20) @(negedge mclk);
    chk(cmd_ready, 1'b0);
    irq = 1'b1;
    send(mcu_bus_pkg::OP_READ, 16'h0006, 8'h00);
    get_resp(d);
    chk(d, 8'h5e);
    send(mcu_bus_pkg::OP_WAIT_LOW, 16'h0000, 8'h00);
    repeat (20) @(negedge mclk);
    chk(cmd_ready, 1'b0);
    irq = 1'b0;
    wait_ready();
    chk(cmd_ready, 1'b1);
  endtask : sc_irq

  // Frozen clock enable stretches the strobe by exactly the frozen cycles
  task automatic sc_freeze;
    int i;
    send(mcu_bus_pkg::OP_WRITE, 16'h000a, 8'h3c);
    for (i = 0; i < 400 && wr_n !== 1'b0; i++) @(negedge mclk);
    if (i == 400) tmo();
    clk_en = 1'b0;
    repeat (20) @(negedge mclk);
    chk(wr_n, 1'b0);
    clk_en = 1'b1;
    wait_ready();
    chk(wr_len, 16'(2 * HD + 20));
    chk(mcu_periph_model_i.mem[10], 8'h3c);
  endtask : sc_freeze

  initial
  begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    sc_reset();
    set_mode(8'h05, 1'b0);
    set_mode(8'h08, 1'b1);
    sc_plain();
    sc_stretch();
    sc_gp();
    sc_irq();
    sc_freeze();
    set_mode(8'h00, 1'b0);
    report_and_stop();
  end
endmodule : mcu_host_bus_emulator_test
